// ===== testbench/dcs_partner.sv
module dcs_partner (
    input  wire logic       clk_sys,           // system clock
    output logic            qualified_write_n, // write pulse, low
    output logic      [2:0] addr_hi,           // address bits 9..11
    output logic            chop_drive,        // chop drive level
    output logic            alt_drive          // alternate drive level
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // processor write pins and mainframe drives
    // ----------------------------------------
    initial
    begin
        qualified_write_n = 1'b1;
        addr_hi = 3'h0;
        chop_drive = 1'b0;
        alt_drive = 1'b0;
    end

    // address outlives the pulse so the delayed strobe never sees it move
    task automatic write_pulse(input logic [2:0] a, input int w);
        @(posedge clk_sys);
        addr_hi <= a;
        @(posedge clk_sys);
        qualified_write_n <= 1'b0;
        repeat (w) @(posedge clk_sys);
        qualified_write_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        addr_hi <= ~a;
    endtask

    task automatic drive_edge(input logic alt);
        @(posedge clk_sys);
        if (alt)
            alt_drive <= ~alt_drive;
        else
            chop_drive <= ~chop_drive;
    endtask
endmodule // dcs_partner

// ===== testbench/dcs_sequencer_bench.sv
module dcs_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int HH = 6;
    localparam int PW = 6;
    localparam logic [11:0] CTRL = dcs_pkg::ADDR_DISPLAY_CTRL;
    localparam logic [11:0] TEST = dcs_pkg::ADDR_DISPLAY_TEST;
    localparam logic [11:0] STAT = dcs_pkg::ADDR_STATUS;

    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  write_strobe_n;
    logic [3:0]  channel_select_n, p12, p34, fin;
    logic        trig_n, readback, horn_en, tone, led_mode, green_n, red_n;
    logic        qw_n, chop, alt;
    logic [2:0]  addr_hi;
    logic [7:0]  pat = 8'h4D;
    int          mismatches = 0;
    int          n_tests = 0;

    always #10 clk_sys = ~clk_sys;

    dcs_sequencer #(.HORN_HALF(HH)) dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .qualified_write_n(qw_n), .addr_hi(addr_hi), .write_strobe_n(write_strobe_n),
        .chop_drive(chop), .alt_drive(alt), .channel_select_n(channel_select_n),
        .trigger_view_select_n(trig_n), .sw_pair12_ctrl_n(p12), .sw_pair34_ctrl_n(p34),
        .sw_final_ctrl_n(fin), .scan_readback_bit(readback), .horn_enable(horn_en),
        .horn_tone(tone), .led_mode(led_mode), .probe_offset_green_led_n(green_n),
        .probe_offset_red_led_n(red_n));

    dcs_partner fpart (.clk_sys(clk_sys), .qualified_write_n(qw_n), .addr_hi(addr_hi),
        .chop_drive(chop), .alt_drive(alt));

    // ----------------------------------------
    // reporting
    // ----------------------------------------
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic bound(input int k, input int lim);
        if (k >= lim)
        begin
            chk("wait bound", 32'h0, 32'h1);
            test_done();
        end
    endtask

    // ----------------------------------------
    // bus and pin access
    // ----------------------------------------
    // answer taken at the edge that samples pready, before that edge's updates land
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        bound(k, 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_rd(input string n, input logic [11:0] a, input logic [31:0] exp);
        apb(a, 1'b0, 32'h0);
        chk(n, exp, rd);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // slot 5 means nothing selected
    task automatic chk_sel(input int i);
        logic [4:0] s;
        s = (i < 5) ? 5'h01 << i : 5'h00;
        chk("select", {27'h0, ~s}, {27'h0, trig_n, channel_select_n});
        chk("switch", {20'h0, 2'h3, ~s[1], ~s[0], 2'h3, ~s[3], ~s[2], ~(s[2] | s[3]), ~(s[0] | s[1]),
            ~s[4], 1'b1}, {20'h0, p12, p34, fin});
    endtask

    task automatic step(input logic src, input int i);
        fpart.drive_edge(src);
        cyc(8);
        chk_sel(i);
    endtask

    task automatic strobe(input logic [2:0] a);
        int k;
        int n;
        fork
            fpart.write_pulse(a, PW);
            begin
                k = 0;
                while (write_strobe_n === 8'hFF && k < 20)
                begin
                    @(posedge clk_sys);
                    k++;
                end
                bound(k, 20);
                chk("strobe", {24'h0, ~(8'h01 << a)}, {24'h0, write_strobe_n});
                n = 0;
                while (write_strobe_n === ~(8'h01 << a) && n < 40)
                begin
                    @(posedge clk_sys);
                    n++;
                end
                chk("strobe width", PW, n);
            end
        join
        cyc(3);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        cyc(20);
        reset_n <= 1'b1;
        cyc(1);
        chk("strobes idle", 32'hFF, {24'h0, write_strobe_n});
        chk_sel(5);
        chk("test outputs", 32'h3, {27'h0, horn_en, tone, led_mode, green_n, red_n});
        chk_rd("ctrl reset", CTRL, 32'h0);
        chk_rd("test reset", TEST, 32'h0);
        apb(CTRL, 1'b1, 32'hFFFF_FFE5);
        chk_rd("ctrl", CTRL, 32'h25);
        chk_rd("unmapped", 12'h00C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(STAT, 1'b1, 32'h3F);
        chk("status write err", 32'h1, {31'h0, err});
        for (int a = 0; a < 8; a++)
            strobe(a[2:0]);
        apb(CTRL, 1'b1, 32'h15);
        step(1'b0, 0);
        step(1'b0, 2);
        step(1'b0, 4);
        step(1'b0, 0);
        apb(CTRL, 1'b1, 32'h10);
        step(1'b0, 4);
        step(1'b0, 4);
        apb(CTRL, 1'b1, 32'h26);
        step(1'b1, 1);
        step(1'b1, 2);
        step(1'b0, 2);
        step(1'b1, 1);
        apb(CTRL, 1'b1, 32'h20);
        step(1'b1, 5);
        apb(TEST, 1'b1, 32'h1);
        cyc(2);
        chk_sel(5);
        for (int k = 0; k < 8; k++)
        begin
            apb(CTRL, 1'b1, {26'h0, 1'b1, 4'h0, pat[k]});
            apb(TEST, 1'b1, 32'h3);
            apb(TEST, 1'b1, 32'h1);
            cyc(2);
            if (k >= 4)
            begin
                chk("readback pin", {31'h0, pat[k-4]}, {31'h0, readback});
                apb(STAT, 1'b0, 32'h0);
                chk("readback status", {31'h0, pat[k-4]}, {31'h0, rd[5]});
            end
        end
        apb(TEST, 1'b1, 32'h1C);
        cyc(1);
        chk("led outputs", 32'hD, {28'h0, horn_en, led_mode, green_n, red_n});
        begin
            int k;
            int n;
            k = 0;
            while (tone !== 1'b1 && k < 3 * HH)
            begin
                @(posedge clk_sys);
                k++;
            end
            bound(k, 3 * HH);
            n = 0;
            while (tone === 1'b1 && n < 3 * HH)
            begin
                @(posedge clk_sys);
                n++;
            end
            chk("tone half period", HH, n);
            // disable while the tone is high, so a tone that keeps running is caught
            k = 0;
            while (tone !== 1'b1 && k < 3 * HH)
            begin
                @(posedge clk_sys);
                k++;
            end
            bound(k, 3 * HH);
        end
        apb(TEST, 1'b1, 32'h20);
        cyc(2);
        chk("horn off", 32'h0, {29'h0, horn_en, tone, red_n});
        test_done();
    end
endmodule // dcs_sequencer_bench

// ===== verilog/dcs_pkg.sv
package dcs_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ           = 50_000_000;
    localparam int unsigned HORN_TONE_HZ     = 4_000;
    localparam int unsigned HORN_HALF_CYCLES = CLK_HZ / (2 * HORN_TONE_HZ);

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned APB_ADDR_W        = 12;
    localparam logic [11:0] ADDR_DISPLAY_CTRL = 12'h000;
    localparam logic [11:0] ADDR_DISPLAY_TEST = 12'h004;
    localparam logic [11:0] ADDR_STATUS       = 12'h008;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int unsigned NUM_SLOTS         = 5;
    localparam int unsigned TRIG_VIEW_SLOT    = 4;
    localparam int unsigned STAT_SELECT_LSB   = 0;
    localparam int unsigned STAT_READBACK_BIT = 5;
    localparam int unsigned STAT_TONE_BIT     = 6;
    localparam int unsigned NUM_STROBES       = 8;

    // bit 0..3 enable channels 1..4, bit 4 trigger view, bit 5 drive source
    typedef struct packed {
        logic       alt_source;
        logic [4:0] enable;
    } dcs_ctrl_type;

    typedef struct packed {
        logic red_led;
        logic green_led;
        logic led_mode;
        logic horn_enable;
        logic scan_shift_clock;
        logic test_mode;
    } dcs_test_type;

    localparam dcs_ctrl_type CTRL_RESET = 6'h00;
    localparam dcs_test_type TEST_RESET = 6'h00;

endpackage

// ===== verilog/dcs_sequencer.sv
// Operation
// - decode qualified write and address into low strobes
// - strobe width equals write pulse width
// - five enable bits: channels one-four, trigger view
// - each sequencer clock selects next enabled channel
// - select outputs active low, at most one; after test mode, several scan ones in sel can show till next drive edge
// - ascending order through enabled, wrap to lowest
// - advance on both edges of chosen drive
// - switch control low routes its input through
// - test high: sequencer shifts enable bit zero (channel one) in
// - test latch drives horn, mode, probe LEDs
// - horn tone free-runs near 4 kHz when enabled
// - horn disabled from reset until software enables
//
// Decided for this implementation: the APB register port and the address map.
module dcs_sequencer #(
    parameter int unsigned HORN_HALF = dcs_pkg::HORN_HALF_CYCLES
) (
    input  wire logic        clk_sys,                  // system clock
    input  wire logic        reset_n,                  // sync reset, active low
    input  wire logic        psel,                     // apb select
    input  wire logic        penable,                  // apb enable
    input  wire logic        pwrite,                   // apb direction
    input  wire logic [11:0] paddr,                    // apb byte address
    input  wire logic [31:0] pwdata,                   // apb write data
    output logic      [31:0] prdata,                   // apb read data
    output logic             pready,                   // apb ready
    output logic             pslverr,                  // apb error
    input  wire logic        qualified_write_n,        // write pulse pin, low
    input  wire logic [2:0]  addr_hi,                  // address bits 9..11
    output logic      [7:0]  write_strobe_n,           // decoded strobes, low
    input  wire logic        chop_drive,               // chop drive pin
    input  wire logic        alt_drive,                // alternate drive pin
    output logic      [3:0]  channel_select_n,         // channels 1..4, low
    output logic             trigger_view_select_n,    // trigger view, low
    output logic      [3:0]  sw_pair12_ctrl_n,         // switch 1/2 ctrl d,c,b,a
    output logic      [3:0]  sw_pair34_ctrl_n,         // switch 3/4 ctrl d,c,b,a
    output logic      [3:0]  sw_final_ctrl_n,          // final switch ctrl d,c,b,a
    output logic             scan_readback_bit,        // scan chain tail
    output logic             horn_enable,              // horn enable level
    output logic             horn_tone,                // horn oscillator
    output logic             led_mode,                 // led driver mode line
    output logic             probe_offset_green_led_n, // green led, low
    output logic             probe_offset_red_led_n    // red led, low
);

    // ------------------------------------------------------------
    // parameter check
    // ------------------------------------------------------------
    localparam int unsigned HW = (HORN_HALF < 2) ? 1 : $clog2(HORN_HALF);

    if (HORN_HALF < 2)
    begin : g_bad_half
        $error("HORN_HALF must be at least 2");
    end

    // ------------------------------------------------------------
    // next enabled slot above the current one, else lowest
    // ------------------------------------------------------------
    function automatic logic [4:0] next_slot(input logic [4:0] cur, input logic [4:0] en);
        logic [4:0] r;
        logic       found;
        r     = 5'h00;
        found = 1'b0;
        for (int i = 0; i < 5; i++)
        begin
            if (!found && en[i] && (cur < (5'h01 << i)))
            begin
                r     = 5'h01 << i;
                found = 1'b1;
            end
        end
        for (int i = 0; i < 5; i++)
        begin
            if (!found && en[i])
            begin
                r     = 5'h01 << i;
                found = 1'b1;
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers: qw, addr(3), chop, alt
    // ------------------------------------------------------------
    logic [5:0] sync_a;
    logic [5:0] sync_b;
    logic [5:0] sync_c;
    logic [5:0] pin_f;

    // a change counts only once stages two and three agree
    wire  [5:0] agree    = ~(sync_b ^ sync_c);
    wire  [5:0] next_pin = (agree & sync_c) | (~agree & pin_f);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sync_a <= 6'h01;
            sync_b <= 6'h01;
            sync_c <= 6'h01;
            pin_f  <= 6'h01;
        end
        else
        begin
            sync_a <= {alt_drive, chop_drive, addr_hi, qualified_write_n};
            sync_b <= sync_a;
            sync_c <= sync_b;
            pin_f  <= next_pin;
        end
    end

    wire       qw_active = ~pin_f[0];
    wire [2:0] addr_f    = pin_f[3:1];
    wire       chop_f    = pin_f[4];
    wire       alt_f     = pin_f[5];

    // ------------------------------------------------------------
    // write strobe decoder
    // ------------------------------------------------------------
    // strobe follows the filtered pulse edge for edge, so its width is the pulse's
    wire [7:0] next_strobe_n = qw_active ? ~(8'h01 << addr_f) : 8'hFF;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
            write_strobe_n <= 8'hFF;
        else
            write_strobe_n <= next_strobe_n;
    end

    // ------------------------------------------------------------
    // apb registers
    // ------------------------------------------------------------
    dcs_pkg::dcs_ctrl_type ctrl;
    dcs_pkg::dcs_test_type test;

    wire apb_wr   = psel & penable & pwrite;
    wire hit_ctrl = paddr == dcs_pkg::ADDR_DISPLAY_CTRL;
    wire hit_test = paddr == dcs_pkg::ADDR_DISPLAY_TEST;
    wire hit_stat = paddr == dcs_pkg::ADDR_STATUS;
    wire wr_ctrl  = apb_wr & hit_ctrl;
    wire wr_test  = apb_wr & hit_test;

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            ctrl <= dcs_pkg::CTRL_RESET;
            test <= dcs_pkg::TEST_RESET;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= dcs_pkg::dcs_ctrl_type'(pwdata[5:0]);
            if (wr_test)
                test <= dcs_pkg::dcs_test_type'(pwdata[5:0]);
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    logic [4:0] sel;
    logic [4:0] shown;
    logic       drv_prev;
    logic       scan_prev;

    wire drv_level = ctrl.alt_source ? alt_f : chop_f;
    wire seq_step  = drv_level != drv_prev;
    wire scan_step = test.scan_shift_clock & ~scan_prev;

    logic [4:0] next_sel;
    always_comb
    begin
        next_sel = sel;
        if (test.test_mode)
        begin
            if (scan_step)
                next_sel = {sel[3:0], ctrl.enable[0]};
        end
        else if (ctrl.enable == 5'h00)
            next_sel = 5'h00;
        else if (seq_step)
            next_sel = next_slot(sel, ctrl.enable);
    end

    // scan data may hold several ones, so test mode blanks the display
    wire [4:0] next_shown = test.test_mode ? 5'h00 : (next_sel & ctrl.enable);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            sel       <= 5'h00;
            shown     <= 5'h00;
            drv_prev  <= 1'b0;
            scan_prev <= 1'b0;
        end
        else
        begin
            sel       <= next_sel;
            shown     <= next_shown;
            drv_prev  <= drv_level;
            scan_prev <= test.scan_shift_clock;
        end
    end

    assign channel_select_n      = ~shown[3:0];
    assign trigger_view_select_n = ~shown[dcs_pkg::TRIG_VIEW_SLOT];
    assign scan_readback_bit     = sel[4];

    // final switch: a unused, b trigger view, c pair 1/2, d pair 3/4
    assign sw_pair12_ctrl_n = ~{2'b00, shown[1], shown[0]};
    assign sw_pair34_ctrl_n = ~{2'b00, shown[3], shown[2]};
    assign sw_final_ctrl_n  = ~{shown[3] | shown[2], shown[1] | shown[0], shown[4], 1'b0};

    // ------------------------------------------------------------
    // horn oscillator and leds
    // ------------------------------------------------------------
    logic [HW-1:0] horn_cnt;
    wire           horn_wrap = horn_cnt == HW'(HORN_HALF - 1);

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n || !test.horn_enable)
        begin
            horn_cnt  <= '0;
            horn_tone <= 1'b0;
        end
        else if (horn_wrap)
        begin
            horn_cnt  <= '0;
            horn_tone <= ~horn_tone;
        end
        else
            horn_cnt <= horn_cnt + 1'b1;
    end

    assign horn_enable              = test.horn_enable;
    assign led_mode                 = test.led_mode;
    assign probe_offset_green_led_n = ~test.green_led;
    assign probe_offset_red_led_n   = ~test.red_led;

    // ------------------------------------------------------------
    // apb read side, zero wait states
    // ------------------------------------------------------------
    wire [31:0] stat_word = {25'h0000000, horn_tone, sel[4], sel};
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ((~hit_ctrl & ~hit_test & ~hit_stat) | (pwrite & hit_stat));
    assign prdata  = hit_ctrl ? {26'h0000000, ctrl} :
                     hit_test ? {26'h0000000, test} :
                     hit_stat ? stat_word : 32'h00000000;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_strobe_decode: assert property (@(posedge clk_sys) disable iff (!reset_n)
        qw_active |=> (write_strobe_n == ~(8'h01 << $past(addr_f)) && $onehot(~write_strobe_n)))
        else $error("strobe decode wrong");

    a_strobe_width: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $fell(qw_active) |=> write_strobe_n == 8'hFF ##0 $past(write_strobe_n) != 8'hFF)
        else $error("strobe width differs from write");

    a_select_exclusive: assert property (@(posedge clk_sys) disable iff (!reset_n)
        $onehot0({~channel_select_n, ~trigger_view_select_n}))
        else $error("more than one select active");

    a_seq_advance: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (seq_step && !test.test_mode && ctrl.enable != 5'h00)
        |=> sel == next_slot($past(sel), $past(ctrl.enable)) ##1 shown == ($past(sel) & $past(ctrl.enable)))
        else $error("sequencer did not advance in order");

    a_both_edges: assert property (@(posedge clk_sys) disable iff (!reset_n)
        ($changed(chop_f) && !ctrl.alt_source && $stable(ctrl.alt_source) && !test.test_mode
         && ctrl.enable != 5'h00 && $past(reset_n))
        |=> sel == next_slot($past(sel), $past(ctrl.enable)))
        else $error("drive edge missed");

    a_none_enabled: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (ctrl.enable == 5'h00) [*2] |-> channel_select_n == 4'hF && trigger_view_select_n)
        else $error("select active with nothing enabled");

    // no $past here: its value before the first edge is not defined the same way everywhere
    a_reset_state: assert property (@(posedge clk_sys)
        !reset_n |=> sel == 5'h00 && !horn_enable && !horn_tone)
        else $error("reset state wrong");

    a_scan_shift: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (scan_step && test.test_mode) |=> sel == {$past(sel[3:0]), $past(ctrl.enable[0])}
        ##0 scan_readback_bit == $past(sel[3]))
        else $error("scan shift wrong");

    a_horn_silent: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !horn_enable |=> !horn_tone && horn_cnt == '0)
        else $error("horn sounds while disabled");

    a_horn_toggle: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (horn_enable && horn_wrap) [*1] ##1 horn_enable |-> $changed(horn_tone) && horn_cnt == '0)
        else $error("horn half period wrong");

    a_test_latch: assert property (@(posedge clk_sys) disable iff (!reset_n)
        wr_test |=> horn_enable == $past(pwdata[2]) && led_mode == $past(pwdata[3])
        && probe_offset_green_led_n == !$past(pwdata[4]) && probe_offset_red_led_n == !$past(pwdata[5]))
        else $error("test latch outputs wrong");

    a_switch_route: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !channel_select_n[2] |-> !sw_pair34_ctrl_n[0] && !sw_final_ctrl_n[3]
        && sw_final_ctrl_n[2:0] == 3'h7 && sw_pair12_ctrl_n == 4'hF)
        else $error("switch routing wrong");

endmodule // dcs_sequencer
